/* File: logic/nv_ram_ctrl_pkg.sv */
package nv_ram_ctrl_pkg;

  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_NS = 50;

  // Worst-case (low supply) figures, in nanoseconds.
  localparam int SELECT_ACTIVE_MIN_TIME_NS = 80;
  localparam int PRECHARGE_MIN_TIME_NS = 65;
  localparam int SELECT_TO_DATA_VALID_NS = 80;
  localparam int DRIVE_ENABLE_TO_DATA_VALID_NS = 15;
  localparam int DRIVE_ENABLE_RELEASE_TIME_NS = 15;
  localparam int WRITE_PULSE_MIN_NS = 50;
  localparam int DATA_SETUP_MIN_NS = 40;

  // Least times round up; every count is at least one cycle.
  function automatic int ceil_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int ACTIVE_CYC = ceil_cycles(SELECT_ACTIVE_MIN_TIME_NS);
  localparam int PRECHARGE_CYC = ceil_cycles(PRECHARGE_MIN_TIME_NS);
  localparam int READ_VALID_CYC = ceil_cycles(SELECT_TO_DATA_VALID_NS + DRIVE_ENABLE_TO_DATA_VALID_NS);
  localparam int RELEASE_CYC = ceil_cycles(DRIVE_ENABLE_RELEASE_TIME_NS);
  localparam int WRITE_PULSE_CYC = ceil_cycles(WRITE_PULSE_MIN_NS);
  localparam int DATA_SETUP_CYC = ceil_cycles(DATA_SETUP_MIN_NS);

  localparam int CNT_W = 4;
  localparam int ROW_BYTES_LOG2 = 3;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ACTIVE,
    ST_RELEASE,
    ST_PRECHARGE
  } cycle_state_t;

endpackage

/* File: logic/nv_ram_cycle_timer.sv */
`timescale 1ns/1ns
`default_nettype none
// Down-counter that reports when a loaded interval has run out.
module nv_ram_cycle_timer
  import nv_ram_ctrl_pkg::*;
#(
  parameter int WIDTH = CNT_W
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic load,
  input wire logic [WIDTH-1:0] loadValue,
  output logic expired
);

  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;

  assign expired = (count_r == '0);
  assign count_nxt = load ? loadValue : (expired ? count_r : count_r - 1'b1);

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

endmodule
`default_nettype wire

/* File: logic/nv_ram_ctrl.sv */
// Operation
// - Controller holds select high at least the minimum precharge time.
// - Controller never holds select low beyond the device's maximum low time.
// - Controller gives every access its own falling select edge.
// - Frequently accessed data should sit in different rows to spread wear.
// - Device never blocks access; controller starts no access at low supply, though one already under way still runs to its end.
// - Controller holds select low at least the minimum active time.
`timescale 1ns/1ns
`default_nettype none
module nv_ram_ctrl
  import nv_ram_ctrl_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqWrite,
  input wire logic [AW-1:0] reqAddr,
  input wire logic [DW-1:0] reqWdata,
  input wire logic supplyGood,
  output logic rspValid,
  output logic [DW-1:0] rspRdata,
  output logic [DW-1:0] lastRow,
  output logic selectN,
  output logic storeN,
  output logic driveEnN,
  output logic [AW-1:0] memAddr,
  output logic [DW-1:0] memDataOut,
  output logic memDataOe,
  input wire logic [DW-1:0] memDataIn
);

  cycle_state_t state_r;
  cycle_state_t state_nxt;
  logic isWrite_r;
  logic [AW-1:0] addr_r;
  logic [DW-1:0] wdata_r;
  logic [DW-1:0] rdata_r;
  logic rspValid_r;
  logic [DW-1:0] lastRow_r;
  logic [CNT_W-1:0] phase_r;
  logic timerLoad;
  logic [CNT_W-1:0] timerValue;
  logic timerExpired;

  logic accept;
  logic inActive;
  logic inRelease;
  logic [CNT_W-1:0] activeCnt;
  logic [CNT_W-1:0] writeCnt;
  logic [CNT_W-1:0] activeLen;
  logic activeDone;
  logic phaseWrap;
  logic selectLow;
  logic storeLow;
  logic driveLow;
  logic hostDrives;

  // A request is taken on the edge where both sides agree.
  assign accept = reqValid && reqReady;
  assign inActive = (state_r == ST_ACTIVE);
  assign inRelease = (state_r == ST_RELEASE);

  // A read must cover the select access time and the drive-enable access time before its sample.
  assign activeCnt = CNT_W'(ACTIVE_CYC > READ_VALID_CYC ? ACTIVE_CYC : READ_VALID_CYC);
  // A write needs data setup plus the store pulse, and never less than the minimum active time.
  assign writeCnt = CNT_W'(ACTIVE_CYC > (DATA_SETUP_CYC + WRITE_PULSE_CYC)
                           ? ACTIVE_CYC : (DATA_SETUP_CYC + WRITE_PULSE_CYC));
  assign activeLen = isWrite_r ? writeCnt : activeCnt;
  assign activeDone = inActive && (phase_r == activeLen - 1'b1);
  assign phaseWrap = inRelease || activeDone;

  assign reqReady = (state_r == ST_IDLE) && supplyGood;

  // One cycle is in flight at a time: idle, active phases, one release cycle, then a counted precharge.
  // own select edge
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (accept) begin
          state_nxt = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (activeDone) begin
          state_nxt = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        state_nxt = ST_PRECHARGE;
      end
      ST_PRECHARGE: begin
        if (timerExpired) begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
  end

  // precharge count
  // The count starts in the release cycle; the idle cycle before the next accept adds margin.
  assign timerLoad = inRelease;
  assign timerValue = CNT_W'(PRECHARGE_CYC - 1);

  nv_ram_cycle_timer #(
    .WIDTH(CNT_W)
  ) u_timer (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .load(timerLoad),
    .loadValue(timerValue),
    .expired(timerExpired)
  );

  assign selectLow = inActive || (inRelease && !isWrite_r);
  assign selectN = !selectLow;
  // store rises before select
  // Store rises a cycle before select, so the write ends on store while data is still driven.
  assign storeLow = inActive && isWrite_r && !activeDone;
  assign storeN = !storeLow;
  assign driveLow = inActive && !isWrite_r;
  assign driveEnN = !driveLow;
  assign memAddr = addr_r;
  assign memDataOut = wdata_r;
  // host drives data on write
  // Data stays driven through the release cycle so that it outlasts the end of the write.
  assign hostDrives = (inActive || inRelease) && isWrite_r;
  assign memDataOe = hostDrives;
  assign rspValid = rspValid_r;
  assign rspRdata = rdata_r;
  assign lastRow = lastRow_r;

  // precharge after reset
  // Reset enters precharge, so a cycle cut short by reset still leaves select high for two cycles.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_r <= ST_PRECHARGE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      phase_r <= '0;
    end else begin
      phase_r <= (phaseWrap || !inActive) ? '0 : phase_r + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      isWrite_r <= 1'b0;
      addr_r <= '0;
      wdata_r <= '0;
    end else if (accept) begin
      isWrite_r <= reqWrite;
      addr_r <= reqAddr;
      wdata_r <= reqWdata;
    end
  end

  // one pulse per access
  // Writes answer as soon as their access ends, since the memory needs no completion polling.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rspValid_r <= 1'b0;
    end else begin
      rspValid_r <= activeDone;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rdata_r <= '0;
    end else if (activeDone && !isWrite_r) begin
      rdata_r <= memDataIn;
    end
  end

  // row exposed for wear
  // Only the low bits of the row number are kept; repeated values hint at one row being worn.
  // row of last access
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      lastRow_r <= '0;
    end else if (accept) begin
      lastRow_r <= DW'(reqAddr[AW-1:ROW_BYTES_LOG2]);
    end
  end

endmodule
`default_nettype wire

/* File: tb/nv_ram_ctrl_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module nv_ram_ctrl_sva
  import nv_ram_ctrl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic reqValid,
  input wire logic reqReady,
  input wire logic supplyGood,
  input wire logic rspValid,
  input wire logic selectN,
  input wire logic storeN,
  input wire logic driveEnN,
  input wire logic memDataOe,
  input wire logic [ADDR_W-1:0] memAddr
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  property p_pre; $rose(selectN) |-> selectN [*2]; endproperty
  a_pre: assert property (p_pre) else $error("precharge too short");
  property p_act; $fell(selectN) |-> !selectN [*2]; endproperty
  a_act: assert property (p_act) else $error("select low too short");
  property p_max; $fell(selectN) |-> ##[2:3] selectN; endproperty
  a_max: assert property (p_max) else $error("select low too long");
  property p_sup; !supplyGood && selectN |=> selectN; endproperty
  a_sup: assert property (p_sup) else $error("access at low supply");
  property p_rdy; !supplyGood |-> !reqReady; endproperty
  a_rdy: assert property (p_rdy) else $error("ready at low supply");
  property p_acc; reqValid && reqReady |=> $fell(selectN); endproperty
  a_acc: assert property (p_acc) else $error("access without select fall");
  property p_wr; $fell(storeN) |-> $fell(selectN); endproperty
  a_wr: assert property (p_wr) else $error("store fell outside cycle start");
  property p_end; rspValid |-> ##[0:1] selectN; endproperty
  a_end: assert property (p_end) else $error("select held after access");
  property p_oe; memDataOe |-> driveEnN; endproperty
  a_oe: assert property (p_oe) else $error("host drives data while memory may drive");
  property p_ds; $rose(storeN) |-> memDataOe; endproperty
  a_ds: assert property (p_ds) else $error("write data gone at end of write");
  property p_adr; !selectN && $past(!selectN) |-> $stable(memAddr); endproperty
  a_adr: assert property (p_adr) else $error("address moved inside a cycle");
endmodule
bind nv_ram_ctrl nv_ram_ctrl_sva u_nv_ram_ctrl_sva (.clk_sys, .rst_b, .reqValid, .reqReady, .supplyGood,
  .rspValid, .selectN, .storeN, .driveEnN, .memDataOe, .memAddr);
`default_nettype wire

/* File: tb/nv_ram_model.sv */
`timescale 1ns/1ns
`default_nettype none
module nv_ram_model
  import nv_ram_ctrl_pkg::*;
(
  input wire logic selectN,
  input wire logic storeN,
  input wire logic driveEnN,
  input wire logic [14:0] memAddr,
  input wire logic [7:0] memDataOut,
  output logic [7:0] memDataIn
);
  logic [7:0] mem [0:32767];
  logic [14:0] addr = 15'h0000;
  logic wc = 1'b0;
  logic pend = 1'b0;
  logic valid = 1'b0;
  logic oeOk = 1'b0;
  logic inCycle = 1'b0;
  int wear [0:4095];
  int timingErr = 0;
  time tRise = 0;
  time tFall = 0;
  always @(negedge selectN) begin
    if ($time - tRise < PRECHARGE_MIN_TIME_NS) timingErr++;
    tFall = $time;
    inCycle = 1'b1;
    #1;
    addr = memAddr;
    wear[addr[14:3]]++;
    wc = !storeN;
    pend = !storeN;
    valid = 1'b0;
    valid <= #79 1'b1;
  end
  always @(posedge selectN) begin
    if (inCycle && $time - tFall < SELECT_ACTIVE_MIN_TIME_NS) timingErr++;
    inCycle = 1'b0;
    tRise = $time;
  end
  always @(negedge storeN) begin
    wc = 1'b1;
    pend = 1'b1;
  end
  always @(posedge storeN or posedge selectN) begin
    if (pend) mem[addr] = memDataOut;
    pend = 1'b0;
  end
  always @(driveEnN) oeOk <= #15 !driveEnN;
  assign memDataIn = (!selectN && !wc && valid && oeOk) ? mem[addr] : ~mem[addr];
endmodule
`default_nettype wire

/* File: tb/nv_ram_ctrl_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module nv_ram_ctrl_tb;
  import nv_ram_ctrl_pkg::*;
  typedef struct packed {logic w; logic [14:0] a; logic [7:0] d;} row_t;
  logic clk_sys = 1'b0, rst_b = 1'b0, reqValid = 1'b0, reqWrite = 1'b0, supplyGood = 1'b1;
  logic [14:0] reqAddr = 15'h0000, memAddr;
  logic [7:0] reqWdata = 8'h00, rspRdata, lastRow, memDataOut, memDataIn;
  logic reqReady, rspValid, selectN, storeN, driveEnN, memDataOe;
  int err_count = 0, n_compared = 0, cycles = 0;
  row_t rows [6] = '{'{1'b1, 15'h0007, 8'h3C}, '{1'b1, 15'h0008, 8'hC3}, '{1'b1, 15'h7FFF, 8'h5A},
    '{1'b0, 15'h7FFF, 8'h5A}, '{1'b0, 15'h0008, 8'hC3}, '{1'b0, 15'h0007, 8'h3C}};
  nv_ram_ctrl u_nv_ram_ctrl (.clk_sys, .rst_b, .reqValid, .reqReady, .reqWrite, .reqAddr, .reqWdata,
    .supplyGood, .rspValid, .rspRdata, .lastRow, .selectN, .storeN, .driveEnN, .memAddr, .memDataOut,
    .memDataOe, .memDataIn);
  nv_ram_model u_nv_ram_model (.selectN, .storeN, .driveEnN, .memAddr, .memDataOut, .memDataIn);
  always #25 clk_sys = ~clk_sys;
  task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task conclude();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task req(input row_t r);
    int n;
    n = 0;
    reqValid <= 1'b1;
    reqWrite <= r.w;
    reqAddr <= r.a;
    reqWdata <= r.d;
    do @(posedge clk_sys); while (reqReady !== 1'b1 && ++n < 20);
    reqValid <= 1'b0;
    do @(posedge clk_sys); while (rspValid !== 1'b1 && ++n < 40);
    check("done", rspValid, 1'b1);
    check("row", lastRow, r.a[10:3]);
    if (!r.w) check("rdata", rspRdata, r.d);
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      conclude();
    end
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    check("select", selectN, 1'b1);
    check("oe", memDataOe, 1'b0);
    check("store", storeN, 1'b1);
    check("drive", driveEnN, 1'b1);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    foreach (rows[i]) req(rows[i]);
    supplyGood <= 1'b0;
    reqValid <= 1'b1;
    repeat (6) @(posedge clk_sys);
    check("select", selectN, 1'b1);
    check("ready", reqReady, 1'b0);
    supplyGood <= 1'b1;
    req(rows[3]);
    reqValid <= 1'b1;
    reqWrite <= 1'b1;
    reqAddr <= 15'h0010;
    reqWdata <= 8'h99;
    @(posedge clk_sys);
    while (reqReady !== 1'b1) @(posedge clk_sys);
    reqValid <= 1'b0;
    @(posedge clk_sys);
    rst_b <= 1'b0;
    @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    check("select", selectN, 1'b1);
    check("store", storeN, 1'b1);
    check("oe", memDataOe, 1'b0);
    check("done", rspValid, 1'b0);
    req(row_t'{1'b0, 15'h0010, 8'h99});
    check("wear", 16'(u_nv_ram_model.wear[4095]), 16'h0003);
    check("wear", 16'(u_nv_ram_model.wear[2]), 16'h0002);
    check("timing", 16'(u_nv_ram_model.timingErr), 16'h0000);
    conclude();
  end
endmodule
`default_nettype wire
